// File: design/pwmdb_pkg.sv
package pwmdb_pkg;
	// Datapath widths
	localparam int CNT_W = 16;
	localparam int DB_W = 12;
	localparam int AXI_AW = 8;
	localparam int NUM_EV = 6;
	// Register byte offsets
	localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_LOAD = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_CMPA = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_CMPB = 8'h0C;
	localparam logic [AXI_AW-1:0] OFS_GENA = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_GENB = 8'h14;
	localparam logic [AXI_AW-1:0] OFS_DBRISE = 8'h18;
	localparam logic [AXI_AW-1:0] OFS_DBFALL = 8'h1C;
	localparam logic [AXI_AW-1:0] OFS_OUTCTL = 8'h20;
	localparam logic [AXI_AW-1:0] OFS_EVSEL = 8'h24;
	localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h28;
	localparam logic [AXI_AW-1:0] OFS_CMD = 8'h2C;
	// Control register fields
	localparam int CTRL_W = 5;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_UPDN = 1;
	localparam int CTRL_SYNCUPD = 2;
	localparam int CTRL_DBGRUN = 3;
	localparam int CTRL_DBEN = 4;
	// Output control fields: enable, invert, fault enable, two bits each
	localparam int OUT_W = 6;
	localparam int OUT_EN_LSB = 0;
	localparam int OUT_INV_LSB = 2;
	localparam int OUT_FLT_LSB = 4;
	// Event select fields
	localparam int EVSEL_W = 14;
	localparam int SEL_INT_LSB = 0;
	localparam int SEL_FLTINT = 6;
	localparam int SEL_TRIG_LSB = 8;
	// Status and command fields
	localparam int ST_DIR = 16;
	localparam int ST_FLT = 17;
	localparam int ST_UPD = 18;
	localparam int ST_RST = 19;
	localparam int CMD_UPD = 0;
	localparam int CMD_RST = 1;
	// Event indices, also the action field index in a generator register
	localparam int EV_ZERO = 0;
	localparam int EV_LOAD = 1;
	localparam int EV_AUP = 2;
	localparam int EV_ADN = 3;
	localparam int EV_BUP = 4;
	localparam int EV_BDN = 5;
	localparam int GEN_W = 2 * NUM_EV;
	// Bus answers and reset values
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Per-event output action
	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_LOW = 2'b10,
		ACT_HIGH = 2'b11
	} pwmdb_act_e;
endpackage : pwmdb_pkg

// File: design/pwmdb_deadband.sv
`timescale 1ns/10ps
module pwmdb_deadband #(
	parameter int DW = pwmdb_pkg::DB_W
) (
	input logic sys_clk,
	input logic rst_n,
	input logic db_en,
	input logic in_a,
	input logic in_b,
	input logic [DW-1:0] rise_dly,
	input logic [DW-1:0] fall_dly,
	output logic out_a,
	output logic out_b
);
	import pwmdb_pkg::*;

	logic [DW-1:0] hi_cnt_r; // Cycles the input has stood high
	logic [DW-1:0] lo_cnt_r; // Cycles the input has stood low

	// Run-length counters saturate so a long level never wraps into a false edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt_r <= '0;
			lo_cnt_r <= '0;
		end else begin
			hi_cnt_r <= !in_a ? '0 : (&hi_cnt_r ? hi_cnt_r : hi_cnt_r + 1'b1);
			lo_cnt_r <= in_a ? '0 : (&lo_cnt_r ? lo_cnt_r : lo_cnt_r + 1'b1);
		end
	end

	// Outputs: pass-through when off, delayed complementary pair when on
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_a <= 1'b0;
			out_b <= 1'b0;
		end else if (!db_en) begin
			out_a <= in_a;
			out_b <= in_b;
		end else begin
			// Second input is dropped; a zero delay adds nothing
			out_a <= in_a && (hi_cnt_r >= rise_dly);
			out_b <= !in_a && (lo_cnt_r >= fall_dly);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_db_pass;
		!db_en |=> (out_a == $past(in_a)) && (out_b == $past(in_b));
	endproperty
	a_db_pass: assert property (p_db_pass) else $error("pass-through broken");

	property p_db_no_overlap;
		db_en && $past(db_en) |-> !(out_a && out_b);
	endproperty
	a_db_no_overlap: assert property (p_db_no_overlap) else $error("pair overlaps");

	property p_db_zero_rise;
		db_en && in_a && rise_dly == '0 |=> out_a;
	endproperty
	a_db_zero_rise: assert property (p_db_zero_rise) else $error("zero delay added");
endmodule : pwmdb_deadband

// File: design/pwmdb_core.sv
`timescale 1ns/10ps
// Behaviour
// - Down mode: load to zero, reload, repeat
// - Up/down mode: zero up to load, back down
// - Direction low in down mode, high counting up
// - Zero and load pulses; load follows zero
// - Match pulses split by direction in up/down
// - Match above load never pulses
// - Four events down mode, six up/down
// - Match coinciding with zero/load is ignored
// - Coinciding matches: A drives A, B drives B
// - Per event, per output: none/toggle/low/high
// - Dead-band off passes both signals unchanged
// - Dead-band on: first output rise delayed
// - Dead-band on: second inverted, fall delayed
// - Selectable interrupt and trigger event sets
// - Interrupt and trigger use raw events
// - Global reset clears the counter
// - Immediate update applies at next zero
// - Synchronous update waits for request, then zero
// - Fault forces fault-enabled outputs inactive, may interrupt
// - Stall halts at zero or runs; no interrupt
// - Enable mask and fault gate the pins
// - Per-output inversion applied last
module pwmdb_core (
	input logic sys_clk,
	input logic rst_n,
	input logic [pwmdb_pkg::AXI_AW-1:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [pwmdb_pkg::AXI_AW-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic fault_in,
	input logic dbg_stall,
	output logic first_pwm_output,
	output logic second_pwm_output,
	output logic int_pulse,
	output logic adc_trig
);
	import pwmdb_pkg::*;

	// Software registers
	logic [CTRL_W-1:0] ctrl_r; // Mode and enable bits
	logic [CNT_W-1:0] ld_sh_r; // Load value as written
	logic [CNT_W-1:0] cmpa_sh_r; // Compare A as written
	logic [CNT_W-1:0] cmpb_sh_r; // Compare B as written
	logic [GEN_W-1:0] gena_r; // Actions for the first signal
	logic [GEN_W-1:0] genb_r; // Actions for the second signal
	logic [DB_W-1:0] dbr_r; // Rising delay
	logic [DB_W-1:0] dbf_r; // Falling delay
	logic [OUT_W-1:0] outc_r; // Enable, invert, fault enable
	logic [EVSEL_W-1:0] evsel_r; // Interrupt and trigger selection
	// Working copies used by the counter
	logic [CNT_W-1:0] ld_act_r;
	logic [CNT_W-1:0] cmpa_act_r;
	logic [CNT_W-1:0] cmpb_act_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic dir_r;
	logic dir_nxt;
	logic upd_pend_r; // Global update requested
	logic rst_pend_r; // Global counter reset requested
	// Synchronisers; stage one feeds stage two only
	logic flt_s1_r, flt_s2_r, flt_d_r;
	logic stl_s1_r, stl_s2_r;
	logic frz_d_r; // Previous cycle was already frozen at zero
	logic gen_a_r, gen_b_r; // Generated signals
	logic db_a, db_b; // After the dead-band stage
	logic [1:0] pin_r; // Final pin stage
	logic int_r, trig_r;
	// Bus state
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [AXI_AW-1:0] awa_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;

	// Control decode
	logic run, updn, syncupd, dbgrun, wr_go, cmd_wr, apply_upd;
	logic freeze, advance, ev_live, zero_hit, load_hit, ma, mb, mok;
	logic [CNT_W-1:0] ld_eff;
	logic [NUM_EV-1:0] ev;
	assign run = ctrl_r[CTRL_RUN];
	assign updn = ctrl_r[CTRL_UPDN];
	assign syncupd = ctrl_r[CTRL_SYNCUPD];
	assign dbgrun = ctrl_r[CTRL_DBGRUN];

	// Byte-lane merge for partial writes
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) old[8*i+:8] = d[8*i+:8];
		end
		return old;
	endfunction : wmerge

	// Offsets that answer OKAY
	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_CMD);
	endfunction : mapped

	// One action applied to the current level
	function automatic logic act(input logic cur, input logic [1:0] code);
		case (pwmdb_act_e'(code))
			ACT_TOGGLE: return !cur;
			ACT_LOW: return 1'b0;
			ACT_HIGH: return 1'b1;
			default: return cur;
		endcase
	endfunction : act

	// Next level of one output; own match beats the other's when both fire
	function automatic logic gen_next(input logic cur, input logic [GEN_W-1:0] g,
		input logic [NUM_EV-1:0] e, input logic is_b);
		logic v;
		int up, dn, oup, odn;
		v = cur;
		up = is_b ? EV_BUP : EV_AUP;
		dn = is_b ? EV_BDN : EV_ADN;
		oup = is_b ? EV_AUP : EV_BUP;
		odn = is_b ? EV_ADN : EV_BDN;
		if (e[EV_ZERO]) v = act(v, g[2*EV_ZERO+:2]);
		if (e[EV_LOAD]) v = act(v, g[2*EV_LOAD+:2]);
		if (e[up] || e[dn]) begin
			v = act(v, e[up] ? g[2*up+:2] : g[2*dn+:2]);
		end else if (e[oup] || e[odn]) begin
			v = act(v, e[oup] ? g[2*oup+:2] : g[2*odn+:2]);
		end
		return v;
	endfunction : gen_next

	// Write channel: address and data are taken in either order
	assign wr_go = !awready_r && !wready_r && !bvalid_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awa_r <= '0;
			wd_r <= RST_WORD;
			ws_r <= '0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				awready_r <= 1'b0;
				awa_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_r) begin
				wready_r <= 1'b0;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= mapped(awa_r) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// Register writes; status is read-only, command is handled below
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= '0;
			ld_sh_r <= '0;
			cmpa_sh_r <= '0;
			cmpb_sh_r <= '0;
			gena_r <= '0;
			genb_r <= '0;
			dbr_r <= '0;
			dbf_r <= '0;
			outc_r <= '0;
			evsel_r <= '0;
		end else if (wr_go) begin
			case (awa_r)
				OFS_CTRL: ctrl_r <= CTRL_W'(wmerge(32'(ctrl_r), wd_r, ws_r));
				OFS_LOAD: ld_sh_r <= CNT_W'(wmerge(32'(ld_sh_r), wd_r, ws_r));
				OFS_CMPA: cmpa_sh_r <= CNT_W'(wmerge(32'(cmpa_sh_r), wd_r, ws_r));
				OFS_CMPB: cmpb_sh_r <= CNT_W'(wmerge(32'(cmpb_sh_r), wd_r, ws_r));
				OFS_GENA: gena_r <= GEN_W'(wmerge(32'(gena_r), wd_r, ws_r));
				OFS_GENB: genb_r <= GEN_W'(wmerge(32'(genb_r), wd_r, ws_r));
				OFS_DBRISE: dbr_r <= DB_W'(wmerge(32'(dbr_r), wd_r, ws_r));
				OFS_DBFALL: dbf_r <= DB_W'(wmerge(32'(dbf_r), wd_r, ws_r));
				OFS_OUTCTL: outc_r <= OUT_W'(wmerge(32'(outc_r), wd_r, ws_r));
				OFS_EVSEL: evsel_r <= EVSEL_W'(wmerge(32'(evsel_r), wd_r, ws_r));
				default: ;
			endcase
		end
	end

	// Read channel: one cycle from address to data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= RST_WORD;
			rresp_r <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				OFS_CTRL: rdata_r <= 32'(ctrl_r);
				OFS_LOAD: rdata_r <= 32'(ld_sh_r);
				OFS_CMPA: rdata_r <= 32'(cmpa_sh_r);
				OFS_CMPB: rdata_r <= 32'(cmpb_sh_r);
				OFS_GENA: rdata_r <= 32'(gena_r);
				OFS_GENB: rdata_r <= 32'(genb_r);
				OFS_DBRISE: rdata_r <= 32'(dbr_r);
				OFS_DBFALL: rdata_r <= 32'(dbf_r);
				OFS_OUTCTL: rdata_r <= 32'(outc_r);
				OFS_EVSEL: rdata_r <= 32'(evsel_r);
				OFS_STATUS: begin
					rdata_r <= 32'(cnt_r);
					rdata_r[ST_DIR] <= dir_r;
					rdata_r[ST_FLT] <= flt_s2_r;
					rdata_r[ST_UPD] <= upd_pend_r;
					rdata_r[ST_RST] <= rst_pend_r;
				end
				OFS_CMD: rdata_r <= 32'({rst_pend_r, upd_pend_r});
				default: rdata_r <= RST_WORD;
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Pending requests; a new request in the clearing cycle wins
	assign cmd_wr = wr_go && (awa_r == OFS_CMD) && ws_r[0];
	assign apply_upd = (cnt_r == '0) && (!syncupd || upd_pend_r);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			upd_pend_r <= 1'b0;
			rst_pend_r <= 1'b0;
		end else begin
			if (cmd_wr && wd_r[CMD_UPD]) upd_pend_r <= 1'b1;
			else if (apply_upd) upd_pend_r <= 1'b0;
			if (cmd_wr && wd_r[CMD_RST]) rst_pend_r <= 1'b1;
			else rst_pend_r <= 1'b0;
		end
	end

	// New limits only at a counter zero, never mid-period
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ld_act_r <= '0;
			cmpa_act_r <= '0;
			cmpb_act_r <= '0;
		end else if (apply_upd) begin
			ld_act_r <= ld_sh_r;
			cmpa_act_r <= cmpa_sh_r;
			cmpb_act_r <= cmpb_sh_r;
		end
	end

	// Two-flop synchronisers for the external levels
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flt_s1_r <= 1'b0;
			flt_s2_r <= 1'b0;
			flt_d_r <= 1'b0;
			stl_s1_r <= 1'b0;
			stl_s2_r <= 1'b0;
		end else begin
			flt_s1_r <= fault_in;
			flt_s2_r <= flt_s1_r;
			flt_d_r <= flt_s2_r;
			stl_s1_r <= dbg_stall;
			stl_s2_r <= stl_s1_r;
		end
	end

	// Stall with halt selected parks the counter once it reaches zero
	assign freeze = stl_s2_r && !dbgrun && (cnt_r == '0);
	assign advance = run && !freeze;
	assign ld_eff = apply_upd ? ld_sh_r : ld_act_r;

	// Counter next state
	always_comb begin
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		if (rst_pend_r) begin
			cnt_nxt = '0;
			dir_nxt = 1'b0;
		end else if (advance) begin
			if (!updn) begin
				dir_nxt = 1'b0;
				cnt_nxt = (cnt_r == '0) ? ld_eff : cnt_r - 1'b1;
			end else if (dir_r) begin
				if (cnt_r >= ld_act_r) begin
					dir_nxt = 1'b0;
					cnt_nxt = (ld_act_r == '0) ? '0 : cnt_r - 1'b1;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end else if (cnt_r == '0) begin
				// A zero load keeps the counter parked at zero
				dir_nxt = (ld_eff != '0);
				cnt_nxt = (ld_eff == '0) ? '0 : CNT_W'(1);
			end else begin
				cnt_nxt = cnt_r - 1'b1;
			end
		end
	end

	// Counter registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			dir_r <= 1'b0;
			frz_d_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			dir_r <= dir_nxt;
			frz_d_r <= freeze && run;
		end
	end

	// Raw events; a counter parked by the stall signals its zero only once
	assign ev_live = run && !rst_pend_r && !(freeze && frz_d_r);
	assign zero_hit = (cnt_r == '0);
	assign load_hit = (cnt_r == ld_act_r);
	assign ma = (cnt_r == cmpa_act_r) && (cmpa_act_r <= ld_act_r);
	assign mb = (cnt_r == cmpb_act_r) && (cmpb_act_r <= ld_act_r);
	assign mok = ev_live && !zero_hit && !load_hit;
	assign ev[EV_ZERO] = ev_live && zero_hit;
	assign ev[EV_LOAD] = ev_live && load_hit;
	assign ev[EV_AUP] = mok && ma && dir_r;
	assign ev[EV_ADN] = mok && ma && !dir_r;
	assign ev[EV_BUP] = mok && mb && dir_r;
	assign ev[EV_BDN] = mok && mb && !dir_r;

	// Signal generator
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_a_r <= 1'b0;
			gen_b_r <= 1'b0;
		end else begin
			gen_a_r <= gen_next(gen_a_r, gena_r, ev, 1'b0);
			gen_b_r <= gen_next(gen_b_r, genb_r, ev, 1'b1);
		end
	end

	pwmdb_deadband #(
		.DW(DB_W)
	) u_db (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.db_en(ctrl_r[CTRL_DBEN]),
		.in_a(gen_a_r),
		.in_b(gen_b_r),
		.rise_dly(dbr_r),
		.fall_dly(dbf_r),
		.out_a(db_a),
		.out_b(db_b)
	);

	// Pin stage: mask, fault gate, then inversion last
	for (genvar i = 0; i < 2; i++) begin : g_pin
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				pin_r[i] <= 1'b0;
			end else begin
				pin_r[i] <= ((i == 0 ? db_a : db_b) && outc_r[OUT_EN_LSB+i]
					&& !(flt_s2_r && outc_r[OUT_FLT_LSB+i]))
					^ outc_r[OUT_INV_LSB+i];
			end
		end
	end

	// Interrupt and trigger from raw events; the stall never contributes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_r <= 1'b0;
			trig_r <= 1'b0;
		end else begin
			int_r <= |(ev & evsel_r[SEL_INT_LSB+:NUM_EV])
				|| (evsel_r[SEL_FLTINT] && flt_s2_r && !flt_d_r);
			trig_r <= |(ev & evsel_r[SEL_TRIG_LSB+:NUM_EV]);
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign first_pwm_output = pin_r[0];
	assign second_pwm_output = pin_r[1];
	assign int_pulse = int_r;
	assign adc_trig = trig_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_down_zero;
		ev[EV_ZERO] && !updn && advance && (ld_eff != '0);
	endsequence
	property p_reload;
		s_down_zero ##0 !rst_pend_r |=> cnt_r == $past(ld_eff);
	endproperty
	a_reload: assert property (p_reload) else $error("no reload after zero");
	property p_load_after_zero;
		s_down_zero |=> ev[EV_LOAD] || rst_pend_r || !run;
	endproperty
	a_load_after_zero: assert property (p_load_after_zero) else $error("load not after zero");
	property p_dir_down;
		!updn && $past(updn) == 1'b0 |-> !dir_r;
	endproperty
	a_dir_down: assert property (p_dir_down) else $error("direction high in down mode");
	property p_no_match_above;
		cmpa_act_r > ld_act_r |-> !ev[EV_AUP] && !ev[EV_ADN];
	endproperty
	a_no_match_above: assert property (p_no_match_above) else $error("match above load");
	property p_ignore_match;
		ev[EV_ZERO] || ev[EV_LOAD] |-> ev[EV_BDN:EV_AUP] == '0;
	endproperty
	a_ignore_match: assert property (p_ignore_match) else $error("match not ignored");
	property p_gbl_reset;
		rst_pend_r |=> cnt_r == '0;
	endproperty
	a_gbl_reset: assert property (p_gbl_reset) else $error("counter not cleared");
	property p_sync_hold;
		syncupd && !upd_pend_r |=> ld_act_r == $past(ld_act_r);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("update without request");
	sequence s_fault_seen;
		fault_in [*2];
	endsequence
	property p_fault_sync;
		s_fault_seen |=> flt_s2_r;
	endproperty
	a_fault_sync: assert property (p_fault_sync) else $error("fault not synchronised");
	property p_fault_pin;
		flt_s2_r && outc_r[OUT_FLT_LSB] |=> first_pwm_output == $past(outc_r[OUT_INV_LSB]);
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("fault did not gate pin");
	property p_mask_inv;
		!outc_r[OUT_EN_LSB+1] |=> second_pwm_output == $past(outc_r[OUT_INV_LSB+1]);
	endproperty
	a_mask_inv: assert property (p_mask_inv) else $error("mask or inversion wrong");
	property p_trig;
		|(ev & evsel_r[SEL_TRIG_LSB+:NUM_EV]) |=> adc_trig;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger missing");
endmodule : pwmdb_core

// File: testbench/pwmdb_bridge_model.sv
`timescale 1ns/10ps
// Half-bridge power stage driven by the two pins
module pwmdb_bridge_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic gate_hi,
	input wire logic gate_lo,
	input wire logic armed,
	output logic phase_out,
	output logic shoot_thru
);
	// Both switches on shorts the supply; sticky so a one-cycle overlap is not missed
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shoot_thru <= 1'b0;
		end else if (!armed) begin
			// Independent pins may overlap legally, so only watch while armed
			shoot_thru <= 1'b0;
		end else if (gate_hi && gate_lo) begin
			shoot_thru <= 1'b1;
		end
	end
	// Phase node follows the conducting switch; floats (changes every cycle) when both off
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_out <= 1'b0;
		end else begin
			phase_out <= gate_hi ? 1'b1 : (gate_lo ? 1'b0 : ~phase_out);
		end
	end
endmodule : pwmdb_bridge_model

// File: testbench/pwm_generator_deadband_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module pwm_generator_deadband_tb;
	import pwmdb_pkg::*;
	logic sys_clk = 1'b0; // 200 MHz
	logic rst_n = 1'b0; // Async, active low
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0, rdata, rd_d;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp, rd_r;
	logic awready, wready, bvalid, arready, rvalid, pa, pb, int_pulse, adc_trig, shoot;
	logic fault_in = 1'b0, dbg_stall = 1'b0; // External conditions
	logic armed = 1'b0; // Overlap watch on the power stage
	int miscompares = 0, checks_done = 0, na, nb, ni, nt;
	always #2.5 sys_clk = ~sys_clk;
	pwmdb_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fault_in(fault_in), .dbg_stall(dbg_stall),
		.first_pwm_output(pa), .second_pwm_output(pb), .int_pulse(int_pulse),
		.adc_trig(adc_trig));
	// Power stage on the pin pair; flags an overlap of the two gates while armed
	pwmdb_bridge_model bridge (.sys_clk(sys_clk), .rst_n(rst_n), .gate_hi(pa),
		.gate_lo(pb), .armed(armed), .phase_out(), .shoot_thru(shoot));
	// Verdict and end of run; also reached from any expired wait
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
		int i;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (i == 50) begin
			miscompares++;
			report_and_stop();
		end
	endtask : wr
	// Read: data and response taken at the edge rvalid is seen
	task automatic rd(input logic [AXI_AW-1:0] a);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rd_d = rdata;
				rd_r = rresp;
				break;
			end
		end
		rready <= 1'b0;
		if (i == 50) begin
			miscompares++;
			report_and_stop();
		end
	endtask : rd
	// Count high cycles of pins and pulses; whole periods keep it phase independent
	task automatic mchk(input int n, input int ea, input int eb, input int ei, input int et);
		na = 0;
		nb = 0;
		ni = 0;
		nt = 0;
		repeat (40) @(posedge sys_clk);
		repeat (n) begin
			@(posedge sys_clk);
			na += (pa === 1'b1);
			nb += (pb === 1'b1);
			ni += (int_pulse === 1'b1);
			nt += (adc_trig === 1'b1);
		end
		`CHK(na, ea)
		`CHK(nb, eb)
		`CHK(ni, ei)
		`CHK(nt, et)
	endtask : mchk
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		// Period 10: A high at zero, low at A-down 4; B low at B-down 7
		wr(OFS_LOAD, 32'h9);
		wr(OFS_CMPA, 32'h4);
		wr(OFS_CMPB, 32'h7);
		wr(OFS_GENA, 32'h83);
		wr(OFS_GENB, 32'h803);
		wr(OFS_OUTCTL, 32'h3);
		wr(OFS_EVSEL, 32'h102);
		wr(OFS_CTRL, 32'h1);
		rd(OFS_CTRL);
		`CHK(rd_d, 32'h1)
		rd(8'h30);
		`CHK(rd_r, RESP_SLVERR)
		$display("test bus done");
		mchk(100, 60, 30, 10, 10);
		$display("test count down done");
		wr(OFS_DBRISE, 32'h2);
		wr(OFS_DBFALL, 32'h1);
		wr(OFS_CTRL, 32'h11);
		// Let the pass-through levels drain from the pins before arming
		repeat (4) @(posedge sys_clk);
		armed <= 1'b1;
		mchk(100, 40, 30, 10, 10);
		wr(OFS_DBRISE, 32'h0);
		mchk(100, 60, 30, 10, 10);
		`CHK(shoot, 1'b0)
		armed <= 1'b0;
		$display("test dead band done");
		wr(OFS_CTRL, 32'h1);
		wr(OFS_OUTCTL, 32'h6);
		mchk(100, 100, 30, 10, 10);
		wr(OFS_OUTCTL, 32'h7);
		mchk(100, 40, 30, 10, 10);
		$display("test output stage done");
		wr(OFS_OUTCTL, 32'h13);
		fault_in <= 1'b1;
		mchk(100, 0, 30, 10, 10);
		fault_in <= 1'b0;
		wr(OFS_OUTCTL, 32'h3);
		// Fault interrupt alone: one pulse per rise of the fault level
		wr(OFS_EVSEL, 32'h140);
		fault_in <= 1'b1;
		ni = 0;
		repeat (10) begin
			@(posedge sys_clk);
			ni += (int_pulse === 1'b1);
		end
		`CHK(ni, 1)
		fault_in <= 1'b0;
		wr(OFS_EVSEL, 32'h102);
		wr(OFS_CMPA, 32'hA);
		mchk(100, 100, 30, 10, 10);
		$display("test fault and range done");
		// Up/down period 8: A high from A-up 2 to A-down 2; B match above load
		wr(OFS_LOAD, 32'h4);
		wr(OFS_CMPA, 32'h2);
		wr(OFS_GENA, 32'hB0);
		wr(OFS_CTRL, 32'h3);
		mchk(96, 48, 96, 12, 12);
		$display("test up down done");
		wr(OFS_LOAD, 32'h9);
		wr(OFS_CMPA, 32'h4);
		wr(OFS_GENA, 32'h83);
		wr(OFS_CTRL, 32'h1);
		dbg_stall <= 1'b1;
		mchk(100, 100, 100, 0, 0);
		dbg_stall <= 1'b0;
		$display("test stall done");
		wr(OFS_CTRL, 32'h5);
		wr(OFS_LOAD, 32'h13);
		mchk(100, 60, 30, 10, 10);
		wr(OFS_CMD, 32'h1);
		mchk(100, 80, 65, 5, 5);
		// Global reset: counter reads zero right after the command lands
		wr(OFS_CMD, 32'h2);
		rd(OFS_STATUS);
		`CHK(rd_d[15:0], 16'h0)
		$display("test sync update done");
		report_and_stop();
	end
endmodule : pwm_generator_deadband_tb
